// *** hdl/pse_builder.sv ***
`timescale 1ns/10ps
// What this block does
// - An event is sent whenever pipe availability or needs-open changes.
// - Frame is length 17, code 0x88, 8 open bytes, 8 needs-open bytes.
// - Pipe n is bit n%8 of byte n/8, first byte sent first.
// - Open map bit is one for an available pipe, zero otherwise.
// - Needs-open bit is one for a pipe that requires opening and is not available.
// - Bits 1 to 62 are pipes 1 to 62; bit 63 is sent as zero.
// - Open map bit 0 reports discovery complete as one, pending as zero.
// - Discovery status reads one when no discovery is required.
// - Needs-open map bit 0 is always sent as zero.
// - A pipe in the open map is usable at once with no further step.
// - A needs-open pipe takes data only after the peer is told to send.
module pse_builder
   import pse_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [63:0] pipe_avail,
   input  wire logic [63:0] pipe_needs_open,
   input  wire logic        disc_done,
   input  wire logic        disc_not_required,
   input  wire logic [63:0] peer_told_send,
   output logic [63:0]      pipe_rx_enable,
   output logic [7:0]       evt_data,
   output logic             evt_valid,
   input  wire logic        evt_ready,
   output logic             evt_busy
);
   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic       rst_s1_q;
   logic       rst_s2_q;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      pse_state_e  st;
      logic [4:0]  idx;
      logic [63:0] open_snap;
      logic [63:0] need_snap;
      logic [63:0] open_last;
      logic [63:0] need_last;
      logic        pend;
      logic        primed;
      logic [63:0] rx_en;
   } pse_s;

   pse_s        s_q;
   pse_s        s_d;
   logic [63:0] open_now;
   logic [63:0] need_now;
   logic        changed;
   logic [7:0]  byte_sel;
   pse_stream_if #(.W(8)) fb ();

   // ---------------------------------------------------------------
   // Map assembly
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PSE_PIPES; g++) begin : g_map
         if (g == PSE_DISC_BIT) begin : g_b0
            assign open_now[g] = disc_done | disc_not_required;
            assign need_now[g] = 1'b0;
         end else if (g == PSE_UNUSED_BIT) begin : g_b63
            assign open_now[g] = 1'b0;
            assign need_now[g] = 1'b0;
         end else begin : g_pipe
            assign open_now[g] = pipe_avail[g];
            assign need_now[g] = pipe_needs_open[g] & ~pipe_avail[g];
         end
      end
   endgenerate

   assign changed = s_q.primed &&
                    ((open_now != s_q.open_last) ||
                     (need_now != s_q.need_last));

   // Byte order: first map byte carries pipes 0..7, LSB = lowest pipe
   always_comb begin
      byte_sel = 8'h00;
      case (s_q.idx)
         5'h00:   byte_sel = PSE_LEN;
         5'h01:   byte_sel = PSE_EVT_CODE;
         default: begin
            if (s_q.idx < 5'h0A) begin
               byte_sel = s_q.open_snap[8*(s_q.idx-5'h02) +: 8];
            end else begin
               byte_sel = s_q.need_snap[8*(s_q.idx-5'h0A) +: 8];
            end
         end
      endcase
   end

   assign fb.data  = byte_sel;
   assign fb.valid = (s_q.st == PSE_SEND);

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.primed = 1'b1;
      if (!s_q.primed || changed) begin
         s_d.open_last = open_now;
         s_d.need_last = need_now;
      end
      // Change seen mid-frame is kept and sent after
      if (changed || !s_q.primed) begin
         s_d.pend = 1'b1;
      end
      // Open pipes run at once, needs-open pipes wait for peer
      for (int i = 0; i < PSE_PIPES; i++) begin
         s_d.rx_en[i] = open_now[i] |
                        (need_now[i] & peer_told_send[i]);
      end
      s_d.rx_en[PSE_DISC_BIT] = 1'b0;
      case (s_q.st)
         PSE_IDLE: begin
            if (s_q.pend && !changed) begin
               s_d.st        = PSE_SEND;
               s_d.idx       = PSE_IDX_RST;
               s_d.open_snap = s_q.open_last;
               s_d.need_snap = s_q.need_last;
               s_d.pend      = 1'b0;
            end
         end
         PSE_SEND: begin
            if (fb.ready) begin
               if (s_q.idx == 5'(PSE_FRAME_LEN - 1)) begin
                  s_d.st  = PSE_IDLE;
                  s_d.idx = PSE_IDX_RST;
               end else begin
                  s_d.idx = s_q.idx + 5'h01;
               end
            end
         end
         default: begin
            s_d.st = PSE_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Output buffer
   // ---------------------------------------------------------------
   pse_fifo #(
      .WIDTH (8),
      .DEPTH (PSE_FIFO_DEPTH)
   ) u_fifo (
      .clk      (mclk),
      .rst_b    (rst_s2_q),
      .wr       (fb.snk),
      .rd_data  (evt_data),
      .rd_valid (evt_valid),
      .rd_ready (evt_ready)
   );

   assign pipe_rx_enable = s_q.rx_en;
   assign evt_busy       = (s_q.st == PSE_SEND) | evt_valid;
endmodule

// *** hdl/pse_fifo.sv ***
`timescale 1ns/10ps
module pse_fifo
   import pse_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = PSE_FIFO_DEPTH
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   pse_stream_if.snk       wr,
   output logic [WIDTH-1:0] rd_data,
   output logic            rd_valid,
   input  wire logic       rd_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } pse_fifo_s;

   pse_fifo_s              s_q;
   pse_fifo_s              s_d;
   logic [WIDTH-1:0]       mem [DEPTH];
   logic                   push;
   logic                   pop;

   assign wr.ready = (s_q.cnt != (AW+1)'(DEPTH));
   assign rd_valid = (s_q.cnt != '0);
   assign push     = wr.valid & wr.ready;
   assign pop      = rd_valid & rd_ready;
   assign rd_data  = mem[s_q.rp];

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.wp = (s_q.wp == AW'(DEPTH-1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = (s_q.rp == AW'(DEPTH-1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[s_q.wp] <= wr.data;
      end
   end
endmodule

// *** hdl/pse_pkg.sv ***
package pse_pkg;
   localparam int          PSE_PIPES      = 64;
   localparam int          PSE_MAP_BYTES  = 8;
   localparam logic [7:0]  PSE_LEN        = 8'h11;
   localparam logic [7:0]  PSE_EVT_CODE   = 8'h88;
   localparam int          PSE_DISC_BIT   = 0;
   localparam int          PSE_UNUSED_BIT = 63;
   localparam int          PSE_FRAME_LEN  = 18;
   localparam int          PSE_FIFO_DEPTH = 8;
   localparam logic [4:0]  PSE_IDX_RST    = 5'h00;

   typedef enum logic [1:0] {
      PSE_IDLE = 2'b00,
      PSE_SEND = 2'b01
   } pse_state_e;
endpackage

// *** hdl/pse_stream_if.sv ***
`timescale 1ns/10ps
interface pse_stream_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic         valid;
   logic         ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// *** tb/pse_builder_properties.sv ***
`timescale 1ns/10ps
module pse_builder_chk
   import pse_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [63:0] pipe_avail,
   input wire logic [63:0] peer_told_send,
   input wire logic [63:0] pipe_rx_enable,
   input wire logic [7:0]  evt_data,
   input wire logic        evt_valid,
   input wire logic        evt_ready,
   input wire logic        evt_busy
);
   // ---
   // Byte position within frame
   // ---
   logic [4:0] pos_q;
   logic [4:0] pos_d;
   always_comb begin
      pos_d = pos_q;
      if (evt_valid && evt_ready) begin
         pos_d = (pos_q == 5'h11) ? 5'h00 : pos_q + 5'h01;
      end
   end
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         pos_q <= 5'h00;
      end else begin
         pos_q <= pos_d;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_valid_hold: assert property (
      evt_valid && !evt_ready |=> evt_valid && $stable(evt_data))
      else $error("byte not held");
   chk_len_byte: assert property (
      evt_valid && pos_q == 5'h00 |-> evt_data == PSE_LEN)
      else $error("bad length byte");
   chk_code_byte: assert property (
      evt_valid && pos_q == 5'h01 |-> evt_data == PSE_EVT_CODE)
      else $error("bad code byte");
   chk_unused_top: assert property (
      evt_valid && (pos_q == 5'h09 || pos_q == 5'h11) |-> !evt_data[7])
      else $error("bit 63 set");
   chk_closed_bit0: assert property (
      evt_valid && pos_q == 5'h0A |-> !evt_data[0])
      else $error("needs-open bit 0 set");
   chk_rx_gate: assert property (
      |pipe_rx_enable[62:1] |-> (pipe_rx_enable[62:1]
      & ~$past(pipe_avail[62:1]) & ~$past(peer_told_send[62:1])) == '0)
      else $error("pipe enabled early");
   chk_rx_bit0: assert property (!pipe_rx_enable[0])
      else $error("rx bit 0 set");
   chk_busy_cover: assert property (evt_valid |-> evt_busy)
      else $error("valid without busy");
   chk_change_sent: assert property (
      $changed(pipe_avail[62:1]) && !evt_busy |-> ##[1:5] evt_valid)
      else $error("no event after change");
endmodule
bind pse_builder pse_builder_chk i_chk (.mclk, .rst_b, .pipe_avail,
   .peer_told_send, .pipe_rx_enable, .evt_data, .evt_valid, .evt_ready,
   .evt_busy);

// *** tb/pse_builder_tb_top.sv ***
`timescale 1ns/10ps
module pse_builder_tb_top;
   import pse_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic [63:0] avail = '0;
   logic [63:0] needs = '0;
   logic        done = 1'b0;
   logic        nreq = 1'b0;
   logic [63:0] told = '0;
   logic        slow = 1'b0;
   logic [63:0] rx_en;
   logic [7:0]  data;
   logic        valid;
   logic        ready;
   logic        busy;
   int          failures = 0;
   int          tests_run = 0;
   initial forever #20 mclk = ~mclk;
   pse_builder i_dut (.mclk, .rst_b, .pipe_avail(avail),
      .pipe_needs_open(needs), .disc_done(done), .disc_not_required(nreq),
      .peer_told_send(told), .pipe_rx_enable(rx_en), .evt_data(data),
      .evt_valid(valid), .evt_ready(ready), .evt_busy(busy));
   pse_host_sink i_host (.mclk, .slow, .evt_data(data), .evt_valid(valid),
      .evt_ready(ready));
   task automatic check(string nm, logic [63:0] seen, logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d errors %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic step(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic frame(logic [63:0] o, logic [63:0] c);
      int i;
      for (i = 0; i < 2000 && (i_host.rx_q.size() < 18 || busy); i++) step(1);
      if (i == 2000) begin
         failures++;
         end_of_test();
      end
      check("count", 64'(i_host.rx_q.size()), 64'd18);
      check("length", i_host.rx_q[0], PSE_LEN);
      check("code", i_host.rx_q[1], PSE_EVT_CODE);
      for (i = 0; i < 8; i++) begin
         check("open", i_host.rx_q[2+i], o[8*i+:8]);
         check("closed", i_host.rx_q[10+i], c[8*i+:8]);
      end
      i_host.rx_q.delete();
   endtask
   task automatic t_example();
      slow = 1'b1;
      avail = 64'h0008_0000_000D_FFFE;
      needs = 64'h0000_1000_1182_0000;
      frame(avail, needs);
      slow = 1'b0;
   endtask
   task automatic t_edges();
      avail = '1;
      needs = '1;
      nreq = 1'b1;
      frame(64'h7FFF_FFFF_FFFF_FFFF, 64'h0);
      nreq = 1'b0;
      done = 1'b1;
      avail = 64'h8000_0000_0000_0001;
      frame(64'h1, 64'h7FFF_FFFF_FFFF_FFFE);
   endtask
   task automatic t_rx();
      avail = 64'h2;
      needs = 64'h4;
      frame(64'h3, 64'h4);
      check("rx_closed", rx_en, 64'h2);
      told = '1;
      step(3);
      check("rx_told", rx_en, 64'h6);
   endtask
   task automatic t_reset();
      rst_b = 1'b0;
      step(2);
      check("rx_in_reset", rx_en, 64'h0);
      check("busy_in_reset", 64'(busy), 64'h0);
      rst_b = 1'b1;
      frame(64'h3, 64'h4);
      check("rx_after_reset", rx_en, 64'h6);
   endtask
   initial begin
      step(8);
      rst_b = 1'b1;
      frame(64'h0, 64'h0);
      t_example();
      t_edges();
      t_rx();
      t_reset();
      end_of_test();
   end
endmodule

// *** tb/pse_host_sink.sv ***
`timescale 1ns/10ps
module pse_host_sink (
   input  wire logic       mclk,
   input  wire logic       slow,
   input  wire logic [7:0] evt_data,
   input  wire logic       evt_valid,
   output logic            evt_ready
);
   logic [7:0] rx_q[$];
   logic [1:0] ph_q = 2'h0;
   // Slow host takes one byte in four cycles
   assign evt_ready = !slow || (ph_q == 2'h3);
   always @(posedge mclk) begin
      ph_q <= ph_q + 2'h1;
      if (evt_valid && evt_ready) begin
         rx_q.push_back(evt_data);
      end
   end
endmodule
